/* File: rtl/pif_flags.sv */
// Interrupt flag logic of the dual regulator device
`default_nettype none

module pif_flags
    import pif_pkg::*;
#(
    parameter int SC_LIMIT = SC_CYCLES  // Cycles of low output before a short is flagged
)
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_B,
    // Register port from the serial interface
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [7:0]  REG_RDATA,
    // Detector events and mask settings
    input  wire pif_evt_type EVT,
    input  wire logic [7:0]  TOP_MASK,
    // Regulator and general output control
    input  wire logic [1:0]  REG_EN_REQ,
    input  wire logic [1:0]  GPO_REQ,
    output logic      [1:0]  REG_EN,
    output logic      [1:0]  GPO_OUT,
    // Interrupt request and interface reset
    output logic             INT_REQ,
    output logic             SERIAL_RESET
);

    // ------------------------------------------------------------
    // Local constants
    // ------------------------------------------------------------
    localparam int              SC_W    = $clog2(SC_LIMIT + 2);   // Short counter width
    localparam logic [SC_W-1:0] SC_LAST = SC_W'(SC_LIMIT);        // Last count before flag
    localparam logic [SC_W-1:0] SC_DONE = SC_W'(SC_LIMIT + 1);    // Saturated count

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]      top_flags_reg,  top_flags_next;   // Latched top flags
    logic            rst_flag_reg,   rst_flag_next;    // Latched reset flag
    logic [7:0]      reg_flags_reg,  reg_flags_next;   // Latched regulator flags
    pif_evt_type     evt_prev_reg;                     // Events one cycle ago
    logic            prev_valid_reg;                   // Event history holds a real sample
    logic [1:0]      en_req_prev_reg;                  // Enable requests one cycle ago
    logic [SC_W-1:0] sc_cnt_reg [2];                   // Low-output run length
    logic [SC_W-1:0] sc_cnt_next [2];
    logic [1:0]      en_reg,         en_next;          // Regulator enables
    logic [1:0]      gpo_reg,        gpo_next;         // General outputs
    logic [7:0]      rdata_reg,      rdata_next;       // Read data
    logic            irq_reg,        irq_next;         // Interrupt request
    logic            ser_rst_reg,    ser_rst_next;     // Interface reset pulse

    // ------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------
    logic       pg_loss;     // Power-good went active to inactive
    logic       sync_chg;    // Sync clock appeared or vanished
    logic       tsd_rise;    // Shutdown level crossed
    logic       twarn_rise;  // Warning level crossed
    logic       ovp_rise;    // Overvoltage level crossed
    logic       software_reset_control;    // Host wrote one to the reset control
    logic       reset_evt;   // Undervoltage or software reset
    logic [7:0] reg_set;     // Regulator flag set terms
    logic [7:0] top_view;    // Top register as software sees it
    pif_evt_type evt_hist;   // Event history used by the edge detectors

    // Until history holds a real sample, events are compared with themselves,
    // so idle levels at reset release never look like an edge
    assign evt_hist   = prev_valid_reg ? evt_prev_reg : EVT;
    assign pg_loss    = evt_hist.power_good_pin & ~EVT.power_good_pin;
    assign sync_chg   = evt_hist.sync_clk_present ^ EVT.sync_clk_present;
    assign tsd_rise   = EVT.thermal_shutdown_live & ~evt_hist.thermal_shutdown_live;
    assign twarn_rise = EVT.thermal_warning_live & ~evt_hist.thermal_warning_live;
    assign ovp_rise   = EVT.overvoltage_live & ~evt_hist.overvoltage_live;
    assign software_reset_control   = REG_WR && REG_ADDR == SOFTWARE_RESET_CONTROL_ADDR && REG_WDATA[SOFTWARE_RESET_CONTROL_BIT];
    assign reset_evt  = EVT.undervoltage | software_reset_control;

    // Summary bit is derived, never stored, so it drops the moment the register empties
    always_comb
    begin
        top_view              = top_flags_reg;
        top_view[TOP_SUM_BIT] = reg_flags_reg != FLAGS_RESET;
    end

    // ------------------------------------------------------------
    // Short-circuit run counters, one per regulator
    // ------------------------------------------------------------
    always_comb
    begin
        reg_set = 8'h00;
        for (int i = 0; i < 2; i++)
        begin
            sc_cnt_next[i] = sc_cnt_reg[i];
            if (reset_evt || !EVT.reg_short_low[i])
            begin
                // Any good sample restarts the run
                sc_cnt_next[i] = '0;
            end
            else if (sc_cnt_reg[i] == SC_LAST)
            begin
                // Low for more than the limit: flag once, then hold
                sc_cnt_next[i]                          = SC_DONE;
                reg_set[REG_SC_BIT0 + i * REG_STRIDE]   = 1'b1;
            end
            else if (sc_cnt_reg[i] != SC_DONE)
            begin
                sc_cnt_next[i] = sc_cnt_reg[i] + 1'b1;
            end
            // Power-good event and current-limit activation
            reg_set[REG_PG_BIT0 + i * REG_STRIDE]   = EVT.reg_pg_event[i];
            reg_set[REG_ILIM_BIT0 + i * REG_STRIDE] =
                EVT.reg_ilim_active[i] & ~evt_hist.reg_ilim_active[i];
        end
    end

    // ------------------------------------------------------------
    // Flag next values: set wins over a clear in the same cycle
    // ------------------------------------------------------------
    always_comb
    begin
        logic [7:0] top_set;   // Top flag set terms
        logic [7:0] top_clr;   // Top flag write-one clears
        logic [7:0] reg_clr;   // Regulator flag write-one clears
        logic       rst_clr;   // Reset flag write-one clear
        top_set                = 8'h00;
        top_set[TOP_PG_BIT]    = pg_loss;
        top_set[TOP_SYNC_BIT]  = sync_chg;
        top_set[TOP_TSD_BIT]   = tsd_rise;
        top_set[TOP_TWARN_BIT] = twarn_rise;
        top_set[TOP_OVP_BIT]   = ovp_rise;
        top_set[TOP_MEAS_BIT]  = EVT.meas_done;
        // Only host-clearable bits react to ones; zeros and other bits are ignored
        top_clr = (REG_WR && REG_ADDR == TOP_FLAGS_ADDR) ? (REG_WDATA & TOP_W1C_MASK)
                                                         : 8'h00;
        reg_clr = (REG_WR && REG_ADDR == REG_FLAGS_ADDR) ? (REG_WDATA & REG_W1C_MASK)
                                                         : 8'h00;
        rst_clr = REG_WR && REG_ADDR == RESET_FLAG_ADDR && (REG_WDATA & RST_W1C_MASK) != 8'h00;
        if (reset_evt)
        begin
            // Registers return to defaults and the reset flag records it in the same cycle
            top_flags_next = FLAGS_RESET;
            reg_flags_next = FLAGS_RESET;
            rst_flag_next  = 1'b1;
        end
        else
        begin
            top_flags_next = ((top_flags_reg & ~top_clr) | top_set) & TOP_W1C_MASK;
            reg_flags_next = ((reg_flags_reg & ~reg_clr) | reg_set) & REG_W1C_MASK;
            rst_flag_next  = rst_flag_reg & ~rst_clr;
        end
    end

    // ------------------------------------------------------------
    // Regulator enables, general outputs, read data, interrupt
    // ------------------------------------------------------------
    always_comb
    begin
        logic [1:0] req_rise;  // New enable requests
        logic       kill;      // Fault or reset turns regulators off
        logic [7:0] irq_src;   // Top sources after masking
        req_rise = REG_EN_REQ & ~en_req_prev_reg;
        kill     = tsd_rise | ovp_rise | reset_evt;
        // A regulator only starts on a fresh request while no shutdown flag stands
        if (kill || top_flags_reg[TOP_TSD_BIT])
        begin
            en_next = 2'b00;
        end
        else
        begin
            en_next = REG_EN_REQ & (en_reg | req_rise);
        end
        // Outputs stay low while a shutdown or overvoltage flag stands
        if (kill || top_flags_next[TOP_TSD_BIT] || top_flags_next[TOP_OVP_BIT])
        begin
            gpo_next = 2'b00;
        end
        else
        begin
            gpo_next = GPO_REQ;
        end
        // Read decode; unmapped and reserved read as zero
        rdata_next = rdata_reg;
        if (REG_RD)
        begin
            unique case (REG_ADDR)
                TOP_FLAGS_ADDR:  rdata_next = top_view;
                RESET_FLAG_ADDR: rdata_next = {7'h00, rst_flag_reg};
                REG_FLAGS_ADDR:  rdata_next = reg_flags_reg;
                TOP_STAT_ADDR:   rdata_next = {EVT.power_good_pin, 2'b00,
                                               ~EVT.sync_clk_present,
                                               EVT.thermal_shutdown_live,
                                               EVT.thermal_warning_live,
                                               EVT.overvoltage_live, 1'b0};
                default:         rdata_next = 8'h00;  // Control bit self-clears
            endcase
        end
        // Interrupt from next flag values so it tracks the flags exactly
        irq_src                = top_flags_next;
        irq_src[TOP_SUM_BIT]   = reg_flags_next != FLAGS_RESET;
        irq_src                = irq_src & ~(TOP_MASK & TOP_MASKABLE);
        irq_next               = (irq_src != 8'h00) | rst_flag_next;
        ser_rst_next           = software_reset_control;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            top_flags_reg   <= FLAGS_RESET;
            rst_flag_reg    <= 1'b0;
            reg_flags_reg   <= FLAGS_RESET;
            evt_prev_reg    <= '0;
            prev_valid_reg  <= 1'b0;
            en_req_prev_reg <= 2'b00;
            sc_cnt_reg[0]   <= '0;
            sc_cnt_reg[1]   <= '0;
            en_reg          <= 2'b00;
            gpo_reg         <= 2'b00;
            rdata_reg       <= 8'h00;
            irq_reg         <= 1'b0;
            ser_rst_reg     <= 1'b0;
        end
        else
        begin
            top_flags_reg   <= top_flags_next;
            rst_flag_reg    <= rst_flag_next;
            reg_flags_reg   <= reg_flags_next;
            evt_prev_reg    <= EVT;
            prev_valid_reg  <= 1'b1;
            en_req_prev_reg <= REG_EN_REQ;
            sc_cnt_reg[0]   <= sc_cnt_next[0];
            sc_cnt_reg[1]   <= sc_cnt_next[1];
            en_reg          <= en_next;
            gpo_reg         <= gpo_next;
            rdata_reg       <= rdata_next;
            irq_reg         <= irq_next;
            ser_rst_reg     <= ser_rst_next;
        end
    end

    assign REG_RDATA    = rdata_reg;
    assign REG_EN       = en_reg;
    assign GPO_OUT      = gpo_reg;
    assign INT_REQ      = irq_reg;
    assign SERIAL_RESET = ser_rst_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    pg_loss_a: assert property (pg_loss && !reset_evt |=> top_flags_reg[TOP_PG_BIT])
        else $error("power-good loss not latched");
    summary_a: assert property (REG_RD && REG_ADDR == TOP_FLAGS_ADDR |=>
        REG_RDATA[TOP_SUM_BIT] == ($past(reg_flags_reg) != 8'h00))
        else $error("summary bit disagrees with regulator flags");
    sync_flag_a: assert property (sync_chg && !reset_evt |=> top_flags_reg[TOP_SYNC_BIT])
        else $error("sync clock change not latched");
    tsd_off_a: assert property (tsd_rise && !reset_evt |=> top_flags_reg[TOP_TSD_BIT]
        && REG_EN == 2'b00 && GPO_OUT == 2'b00)
        else $error("shutdown did not stop outputs");
    tsd_refuse_a: assert property (top_flags_reg[TOP_TSD_BIT] |=> REG_EN == 2'b00)
        else $error("regulator enabled under shutdown flag");
    ovp_off_a: assert property (ovp_rise && !reset_evt |=> top_flags_reg[TOP_OVP_BIT]
        && REG_EN == 2'b00 && GPO_OUT == 2'b00)
        else $error("overvoltage did not stop outputs");
    uv_reset_a: assert property (EVT.undervoltage |=> rst_flag_reg
        && top_flags_reg == 8'h00 && REG_EN == 2'b00)
        else $error("undervoltage reset incomplete");
    short_time_a: assert property ($rose(reg_flags_reg[REG_SC_BIT0]) |->
        $past(sc_cnt_reg[0]) == SC_LAST)
        else $error("short flag set before the time limit");
    zero_write_a: assert property (REG_WR && REG_WDATA == 8'h00 && !reset_evt |=>
        ($past(reg_flags_reg) & ~reg_flags_reg) == 8'h00)
        else $error("zero write cleared a flag");
    irq_cause_a: assert property (INT_REQ |-> top_flags_reg != 8'h00 || rst_flag_reg
        || reg_flags_reg != 8'h00)
        else $error("interrupt without pending flag");

endmodule : pif_flags

`default_nettype wire

/* File: rtl/pif_pkg.sv */
// Package for the regulator interrupt flag block: offsets, bit positions and timing
`default_nettype none

package pif_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SOFTWARE_RESET_CONTROL_ADDR   = 8'h18;  // Software reset control
    localparam logic [7:0] TOP_FLAGS_ADDR  = 8'h19;  // Top event flags
    localparam logic [7:0] RESET_FLAG_ADDR = 8'h1A;  // Reset event flag
    localparam logic [7:0] REG_FLAGS_ADDR  = 8'h1B;  // Per-regulator event flags
    localparam logic [7:0] TOP_STAT_ADDR   = 8'h1D;  // Live top status

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TOP_PG_BIT     = 7;  // Power-good loss
    localparam int TOP_SUM_BIT    = 5;  // Regulator summary
    localparam int TOP_SYNC_BIT   = 4;  // Sync clock change
    localparam int TOP_TSD_BIT    = 3;  // Thermal shutdown
    localparam int TOP_TWARN_BIT  = 2;  // Thermal warning
    localparam int TOP_OVP_BIT    = 1;  // Input overvoltage
    localparam int TOP_MEAS_BIT   = 0;  // Measurement ready
    localparam int RST_FLAG_BIT   = 0;  // Reset event
    localparam int SOFTWARE_RESET_CONTROL_BIT   = 0;  // Software reset control
    localparam int REG_PG_BIT0    = 2;  // Regulator 0 power good, regulator 1 is +4
    localparam int REG_SC_BIT0    = 1;  // Regulator 0 short, regulator 1 is +4
    localparam int REG_ILIM_BIT0  = 0;  // Regulator 0 current limit, regulator 1 is +4
    localparam int REG_STRIDE     = 4;  // Distance between regulator fields

    // ------------------------------------------------------------
    // Masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] TOP_W1C_MASK  = 8'h9F;  // Host-clearable top bits
    localparam logic [7:0] RST_W1C_MASK  = 8'h01;  // Host-clearable reset bit
    localparam logic [7:0] REG_W1C_MASK  = 8'h77;  // Host-clearable regulator bits
    localparam logic [7:0] TOP_MASKABLE  = 8'h95;  // Top events that own a mask bit
    localparam logic [7:0] FLAGS_RESET   = 8'h00;  // Value of the top and regulator flag registers at reset

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;       // 40 MHz clock
    localparam int SC_TIME_NS    = 1000000;  // Short must last beyond 1 ms
    localparam int SC_CYCLES     = (SC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Event inputs from the analog detectors
    // ------------------------------------------------------------
    typedef struct packed {
        logic       power_good_pin;         // Power-good pin, 1 = active
        logic       sync_clk_present;       // External sync clock seen
        logic       thermal_shutdown_live;  // Above shutdown level
        logic       thermal_warning_live;   // Above warning level
        logic       overvoltage_live;       // Input above overvoltage level
        logic       meas_done;              // New load-current result stored
        logic       undervoltage;           // Analog supply below threshold
        logic [1:0] reg_pg_event;           // Per-regulator power-good event
        logic [1:0] reg_short_low;          // Output below short threshold
        logic [1:0] reg_ilim_active;        // Output current limit active
    } pif_evt_type;

endpackage : pif_pkg

`default_nettype wire

/* File: bench/pif_host.sv */
// Host model that reads and writes the flag registers over the register port
`default_nettype none

module pif_host
    import pif_pkg::*;
(
    // Clock
    input  wire logic       clk,
    // Register port toward the flag block
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    input  wire logic [7:0] reg_rdata,
    // Interface reset seen from the block
    input  wire logic       serial_reset
);
    timeunit 1ns;
    timeprecision 1ps;

    logic sr_seen;  // Interface reset level just after the last write

    // ------------------------------------------------------------
    // Idle bus
    // ------------------------------------------------------------
    initial
    begin
        reg_addr  = 8'hFF;
        reg_wdata = 8'hFF;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        sr_seen   = 1'b0;
    end

    // One-cycle write; afterwards the bus shows the inverse, not stale values
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        reg_addr  <= addr;
        reg_wdata <= data;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~addr;
        reg_wdata <= ~data;
        #1;
        sr_seen = serial_reset;
    endtask : write_reg

    // One-cycle read; data is registered at the sampling edge
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk);
        reg_addr <= addr;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~addr;
        #1;
        data = reg_rdata;
    endtask : read_reg

endmodule : pif_host

`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking testbench of the regulator interrupt flag block
`default_nettype none

`define CHK(name, exp, got) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            err_total++; \
            $display("mismatch %s expected %0h seen %0h", name, exp, got); \
        end \
    end

module testbench
    import pif_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int SC_LIM = 8;       // Short-circuit count, shortened for simulation
    logic        clk, rst_b;         // Clock and active-low reset
    pif_evt_type evt;                // Detector events
    logic [7:0]  top_mask;           // Interrupt masks
    logic [1:0]  reg_en_req, gpo_req, reg_en, gpo_out;  // Regulator and output control
    logic        int_req, serial_reset;              // Request and interface reset
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;     // Register port
    logic        reg_wr, reg_rd;                     // Register strobes
    int          err_total, total_checks;            // Verdict counters
    logic [7:0]  top_bits [5] = '{8'h80, 8'h10, 8'h04, 8'h01, 8'h10};  // Event to flag

    pif_flags #(.SC_LIMIT(SC_LIM)) u_pif_flags (
        .CLK(clk), .RST_B(rst_b), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .EVT(evt),
        .TOP_MASK(top_mask), .REG_EN_REQ(reg_en_req), .GPO_REQ(gpo_req),
        .REG_EN(reg_en), .GPO_OUT(gpo_out), .INT_REQ(int_req), .SERIAL_RESET(serial_reset));

    pif_host u_pif_host (
        .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_reset(serial_reset));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Read a register and compare it
    task automatic expect_reg(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] data;
        u_pif_host.read_reg(addr, data);
        `CHK("register", exp, data)
    endtask : expect_reg

    // Let an event reach the flags and the request output
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    // Print the verdict and stop
    task automatic conclude;
        if (err_total == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Flags and request are clear after reset; unmapped read gives zero
    task automatic check_reset;
        expect_reg(TOP_FLAGS_ADDR, 8'h00);
        expect_reg(RESET_FLAG_ADDR, 8'h00);
        expect_reg(REG_FLAGS_ADDR, 8'h00);
        expect_reg(8'h30, 8'h00);
        `CHK("int_req", 1'b0, int_req)
    endtask : check_reset

    // Maskable events: latch, mask, zero write ignored, one write clears
    task automatic check_top_events;
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk);
            case (i)
                0: evt.power_good_pin <= 1'b0;                          // Loss of good
                2: evt.thermal_warning_live <= 1'b1;                    // Warning crossed
                3: evt.meas_done <= 1'b1;                               // New result
                default: evt.sync_clk_present <= ~evt.sync_clk_present; // Vanish, appear
            endcase
            @(posedge clk);
            evt.meas_done <= 1'b0;
            settle();
            `CHK("int_req", 1'b1, int_req)
            expect_reg(TOP_FLAGS_ADDR, top_bits[i]);
            top_mask <= top_bits[i];
            settle();
            `CHK("masked int_req", 1'b0, int_req)
            top_mask <= 8'h00;
            u_pif_host.write_reg(TOP_FLAGS_ADDR, 8'h00);
            expect_reg(TOP_FLAGS_ADDR, top_bits[i]);
            u_pif_host.write_reg(TOP_FLAGS_ADDR, top_bits[i]);
            expect_reg(TOP_FLAGS_ADDR, 8'h00);
            `CHK("int_req", 1'b0, int_req)
            evt.power_good_pin       <= 1'b1;
            evt.thermal_warning_live <= 1'b0;
        end
    endtask : check_top_events

    // Thermal shutdown and overvoltage stop the regulators and outputs
    task automatic check_protection;
        for (int j = 0; j < 2; j++)
        begin
            @(posedge clk);
            gpo_req    <= 2'b11;
            reg_en_req <= 2'b11;
            settle();
            `CHK("reg_en", 2'b11, reg_en)
            @(posedge clk);
            if (j == 0)
                evt.thermal_shutdown_live <= 1'b1;
            else
                evt.overvoltage_live <= 1'b1;
            settle();
            `CHK("reg_en", 2'b00, reg_en)
            `CHK("gpo_out", 2'b00, gpo_out)
            expect_reg(TOP_FLAGS_ADDR, j ? 8'h02 : 8'h08);
            reg_en_req <= 2'b00;
            @(posedge clk);
            reg_en_req <= 2'b11;
            settle();
            `CHK("reg_en", j ? 2'b11 : 2'b00, reg_en)
            u_pif_host.write_reg(TOP_FLAGS_ADDR, 8'h0A);
            expect_reg(TOP_STAT_ADDR, j ? 8'h82 : 8'h88);
            `CHK("gpo_out", 2'b11, gpo_out)
            reg_en_req <= 2'b00;
            evt.thermal_shutdown_live <= 1'b0;
            evt.overvoltage_live      <= 1'b0;
            @(posedge clk);
            reg_en_req <= 2'b11;
            settle();
            `CHK("reg_en", 2'b11, reg_en)
        end
    endtask : check_protection

    // Per-regulator flags, summary bit and the short-circuit time
    task automatic check_regulators;
        @(posedge clk);
        evt.reg_pg_event    <= 2'b11;
        evt.reg_ilim_active <= 2'b11;
        @(posedge clk);
        evt.reg_pg_event    <= 2'b00;
        settle();
        expect_reg(REG_FLAGS_ADDR, 8'h55);
        expect_reg(TOP_FLAGS_ADDR, 8'h20);
        u_pif_host.write_reg(TOP_FLAGS_ADDR, 8'h60);
        expect_reg(TOP_FLAGS_ADDR, 8'h20);
        u_pif_host.write_reg(REG_FLAGS_ADDR, 8'h11);
        expect_reg(REG_FLAGS_ADDR, 8'h44);
        u_pif_host.write_reg(REG_FLAGS_ADDR, 8'h44);
        expect_reg(TOP_FLAGS_ADDR, 8'h00);
        evt.reg_short_low <= 2'b11;
        repeat (SC_LIM) @(posedge clk);
        evt.reg_short_low <= 2'b00;
        expect_reg(REG_FLAGS_ADDR, 8'h00);
        evt.reg_short_low <= 2'b11;
        repeat (SC_LIM + 1) @(posedge clk);
        evt.reg_short_low <= 2'b00;
        expect_reg(REG_FLAGS_ADDR, 8'h22);
        u_pif_host.write_reg(REG_FLAGS_ADDR, 8'h22);
        expect_reg(REG_FLAGS_ADDR, 8'h00);
    endtask : check_regulators

    // Software reset sets the reset flag and clears the rest; undervoltage sets the reset flag
    task automatic check_resets;
        @(posedge clk);
        evt.meas_done <= 1'b1;
        @(posedge clk);
        evt.meas_done <= 1'b0;
        expect_reg(TOP_FLAGS_ADDR, 8'h01);
        u_pif_host.write_reg(SOFTWARE_RESET_CONTROL_ADDR, 8'h01);
        `CHK("serial_reset", 1'b1, u_pif_host.sr_seen)
        `CHK("reg_en", 2'b00, reg_en)
        expect_reg(TOP_FLAGS_ADDR, 8'h00);
        expect_reg(SOFTWARE_RESET_CONTROL_ADDR, 8'h00);
        expect_reg(RESET_FLAG_ADDR, 8'h01);
        `CHK("int_req", 1'b1, int_req)
        u_pif_host.write_reg(RESET_FLAG_ADDR, 8'hFE);
        expect_reg(RESET_FLAG_ADDR, 8'h01);
        u_pif_host.write_reg(RESET_FLAG_ADDR, 8'h01);
        expect_reg(RESET_FLAG_ADDR, 8'h00);
        @(posedge clk);
        evt.undervoltage <= 1'b1;
        @(posedge clk);
        evt.undervoltage <= 1'b0;
        expect_reg(RESET_FLAG_ADDR, 8'h01);
    endtask : check_resets

    // ------------------------------------------------------------
    // Clock, main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial
    begin
        rst_b = 1'b0;
        evt = '0;
        evt.power_good_pin   = 1'b1;
        evt.sync_clk_present = 1'b1;
        {top_mask, reg_en_req, gpo_req} = '0;
        err_total    = 0;
        total_checks = 0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        check_reset();
        check_top_events();
        check_protection();
        check_regulators();
        check_resets();
        conclude();
    end

    // Cuts a hang short
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        conclude();
    end

endmodule : testbench

`default_nettype wire
